/* File: design/cache_descriptor.v */
// Builds one twelve-bit cache descriptor from a size parameter.
// Assumes size is a power of two between 4KB and 128KB.
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_coproc_consts.vh"
module cache_descriptor #(
  parameter SIZE_KB = 16
) (
  output wire [11:0] descriptor
);
  // ==========================================================
  // Log2 of size; code is log2(KB)+1, so 4KB gives b0011
  function [3:0] size_code;
    input integer kb;
    integer i;
    begin
      size_code = 4'h0;
      for (i = 0; i < 16; i = i + 1)
        if ((32'h1 << i) == kb)
          size_code = i[3:0] + `CACHE_SIZE_CODE_OFS;
    end
  endfunction
  localparam [3:0] SIZE_CODE = size_code(SIZE_KB);
  // Fixed four-way, eight-word, present cache
  assign descriptor = {`ZERO2, SIZE_CODE, `CACHE_ASSOC_4WAY,
    `CACHE_MULT_PRESENT, `CACHE_LEN_8WORD};
endmodule // cache_descriptor
`default_nettype wire

/* File: design/sysctl_coproc_consts.vh */
// Constants for the system-control coprocessor register-zero group.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef SYSCTL_COPROC_CONSTS_VH
`define SYSCTL_COPROC_CONSTS_VH
// ==========================================================
// Instruction fields
`define XFER_DIR_BIT 20
`define XFER_PRI_HI 19
`define XFER_PRI_LO 16
`define XFER_RD_HI 15
`define XFER_RD_LO 12
`define XFER_OP1_HI 23
`define XFER_OP1_LO 21
`define XFER_OP2_HI 7
`define XFER_OP2_LO 5
`define XFER_SEC_HI 3
`define XFER_SEC_LO 0
`define XFER_CPNUM_HI 11
`define XFER_CPNUM_LO 8
`define SYSCTL_CPNUM 4'hf
`define PRI_REG_ZERO 4'h0
`define OP2_ID 3'h0
`define OP2_CACHE 3'h1
`define OP2_TCM 3'h2
// ==========================================================
// Cache geometry codes
`define CACHE_METHOD 4'he
`define CACHE_SPLIT 1'h1
`define CACHE_ASSOC_4WAY 3'h2
`define CACHE_MULT_PRESENT 1'h0
`define CACHE_LEN_8WORD 2'h2
`define CACHE_MIN_LOG2_KB 4'h2
`define CACHE_SIZE_CODE_OFS 4'h1
`define ZERO3 3'h0
`define ZERO2 2'h0
// ==========================================================
// Response reset values
`define RESP_RESET_WORD 32'h00000000
`define RESP_RESET_RD 4'h0
`endif

/* File: design/sysctl_coproc_id_regs.v */
// Register-zero group of the system-control coprocessor: decode and read data.
// Assumes the core presents one transfer per xfer_valid pulse on clk.
// Assumes transfer inputs come from logic on clk, so they are not synchronised.
// Reads answer one enabled cycle after the transfer; privileged writes get no answer.
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_coproc_consts.vh"
module sysctl_coproc_id_regs #(
  parameter DCACHE_KB = 8,
  parameter ICACHE_KB = 16,
  parameter [7:0] IMPLEMENTER = 8'h5a, // Arbitrary value
  parameter [3:0] VARIANT = 4'h1, // Arbitrary value
  parameter [3:0] ARCH = 4'h2, // Arbitrary value
  parameter [11:0] PART = 12'h123, // Arbitrary value
  parameter [3:0] REVISION = 4'h3, // Arbitrary value
  parameter [31:0] TCM_STATUS = 32'h00000000
) (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire xfer_valid,
  input wire [31:0] xfer_instr,
  input wire privileged,
  output reg read_valid_r,
  output reg [31:0] read_data_r,
  output reg [3:0] read_rd_r,
  output reg undef_trap_r
);

  // ==========================================================
  // Access classes of one presented transfer
  localparam [1:0] ACC_NONE = 2'h0; // No transfer, or another coprocessor
  localparam [1:0] ACC_READ = 2'h1; // Privileged read of register zero
  localparam [1:0] ACC_TRAP = 2'h2; // Unprivileged; the core must trap
  localparam [1:0] ACC_SKIP = 2'h3; // Privileged write, or privileged read of another register

  // ==========================================================
  // Field helpers, shared by every multi-bit field decode below
  // Four-bit field whose low bit is given by a field macro
  function [3:0] nibble_at;
    input [31:0] word;
    input integer lo;
    begin
      nibble_at = word[lo +: 4];
    end
  endfunction

  // Three-bit field whose low bit is given by a field macro
  function [2:0] triple_at;
    input [31:0] word;
    input integer lo;
    begin
      triple_at = word[lo +: 3];
    end
  endfunction

  // Privilege is tested before direction, so an unprivileged write traps as well
  function [1:0] classify;
    input valid;
    input hit;
    input priv;
    input rd_dir;
    input zero_sel;
    begin
      if (!valid || !hit)
        classify = ACC_NONE;
      else if (!priv)
        classify = ACC_TRAP;
      else if (rd_dir && zero_sel)
        classify = ACC_READ;
      else
        classify = ACC_SKIP;
    end
  endfunction

  // Word picked by the second opcode; unlisted values give the identity
  function [31:0] select_word;
    input [2:0] sel;
    input [31:0] ident;
    input [31:0] geometry;
    input [31:0] tcm;
    begin
      case (sel)
        `OP2_ID: select_word = ident;
        `OP2_CACHE: select_word = geometry;
        `OP2_TCM: select_word = tcm;
        default: select_word = ident;
      endcase
    end
  endfunction

  // ==========================================================
  // Cache descriptors, one per cache, from the build sizes
  wire [11:0] dcache_desc;
  wire [11:0] icache_desc;

  // Data cache
  cache_descriptor #(
    .SIZE_KB(DCACHE_KB)
  ) u_dcache (
    .descriptor(dcache_desc)
  );

  // Instruction cache
  cache_descriptor #(
    .SIZE_KB(ICACHE_KB)
  ) u_icache (
    .descriptor(icache_desc)
  );

  // ==========================================================
  // Identity word; each field is a build parameter
  wire [7:0] id_implementer = IMPLEMENTER;
  wire [3:0] id_variant = VARIANT;
  wire [3:0] id_arch = ARCH;
  wire [11:0] id_part = PART;
  wire [3:0] id_revision = REVISION;

  // Assembled identity
  wire [31:0] ident_word;

  // Implementer on top, revision at the bottom
  assign ident_word = {
    id_implementer,
    id_variant,
    id_arch,
    id_part,
    id_revision
  };

  // ==========================================================
  // Cache geometry word; fixed top byte, then the two descriptors
  wire [2:0] geo_reserved = `ZERO3;
  wire [3:0] geo_method = `CACHE_METHOD;
  wire geo_split = `CACHE_SPLIT;

  // Assembled geometry
  wire [31:0] cache_word;

  // Data descriptor above the instruction descriptor
  assign cache_word = {
    geo_reserved,
    geo_method,
    geo_split,
    dcache_desc,
    icache_desc
  };

  // TCM status layout is left to the build
  wire [31:0] tcm_word = TCM_STATUS;

  // ==========================================================
  // Decode of the presented instruction word
  // Fields
  wire is_read;
  wire [3:0] pri_sel;
  wire [3:0] rd_idx;
  wire [3:0] cp_num;
  wire [2:0] op2;

  // Classification results
  wire cp_hit;
  wire reg0;
  wire [1:0] acc_class;

  // Field split; opcode one and the secondary selector are not decoded
  assign is_read = xfer_instr[`XFER_DIR_BIT];
  assign pri_sel = nibble_at(xfer_instr, `XFER_PRI_LO);
  assign rd_idx = nibble_at(xfer_instr, `XFER_RD_LO);
  assign cp_num = nibble_at(xfer_instr, `XFER_CPNUM_LO);
  assign op2 = triple_at(xfer_instr, `XFER_OP2_LO);

  // Other coprocessor numbers belong to other units and get no answer
  assign cp_hit = cp_num == `SYSCTL_CPNUM;
  assign reg0 = pri_sel == `PRI_REG_ZERO;
  assign acc_class = classify(
    xfer_valid,
    cp_hit,
    privileged,
    is_read,
    reg0
  );

  // ==========================================================
  // Next values of the response registers
  // Strobes
  reg read_valid_nxt;
  reg undef_trap_nxt;

  // Held read results
  reg [3:0] read_rd_nxt;
  reg [31:0] read_data_nxt;

  // Read strobe; writes and other registers answer nothing
  always @*
  begin
    case (acc_class)
      ACC_READ:
      begin
        read_valid_nxt = 1'h1;
      end
      default:
      begin
        read_valid_nxt = 1'h0;
      end
    endcase
  end

  // Trap strobe for unprivileged transfers
  always @*
  begin
    case (acc_class)
      ACC_TRAP:
      begin
        undef_trap_nxt = 1'h1;
      end
      default:
      begin
        undef_trap_nxt = 1'h0;
      end
    endcase
  end

  // Destination index holds until the next read
  always @*
  begin
    if (acc_class == ACC_READ)
    begin
      read_rd_nxt = rd_idx;
    end
    else
    begin
      read_rd_nxt = read_rd_r;
    end
  end

  // Read word holds until the next read, so a late reader still sees it
  always @*
  begin
    if (acc_class == ACC_READ)
    begin
      read_data_nxt = select_word(
        op2,
        ident_word,
        cache_word,
        tcm_word
      );
    end
    else
    begin
      read_data_nxt = read_data_r;
    end
  end

  // ==========================================================
  // Response registers; clk_en low freezes every one of them
  // Read strobe register
  always @(posedge clk)
  begin
    if (reset)
    begin
      read_valid_r <= 1'h0;
    end
    else if (clk_en)
    begin
      read_valid_r <= read_valid_nxt;
    end
  end

  // Trap strobe register
  always @(posedge clk)
  begin
    if (reset)
    begin
      undef_trap_r <= 1'h0;
    end
    else if (clk_en)
    begin
      undef_trap_r <= undef_trap_nxt;
    end
  end

  // Read word register
  always @(posedge clk)
  begin
    if (reset)
    begin
      read_data_r <= `RESP_RESET_WORD;
    end
    else if (clk_en)
    begin
      read_data_r <= read_data_nxt;
    end
  end

  // Destination index register
  always @(posedge clk)
  begin
    if (reset)
    begin
      read_rd_r <= `RESP_RESET_RD;
    end
    else if (clk_en)
    begin
      read_rd_r <= read_rd_nxt;
    end
  end

endmodule // sysctl_coproc_id_regs
`default_nettype wire

/* File: sim/core_model.sv */
// Model of the integer core issuing coprocessor read and write transfers.
// Assumes calls start just after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
// ====
// Core model
module core_model (
  input wire logic clk,
  output logic xfer_valid,
  output var logic [31:0] xfer_instr = 32'h0,
  output var logic privileged = 1'b0
);
  // Quiet lines at time zero
  initial idle();
  // One transfer per call, so calls chain back to back
  task issue(input logic [3:0] pri, input logic [2:0] op, input logic [3:0] rd, input logic pv, input logic rdn);
    xfer_valid = 1'b1;
    privileged = pv;
    xfer_instr = {8'hee, 3'h0, rdn, pri, rd, 4'hf, op, 1'h1, 4'h0};
    @(posedge clk);
    #1;
  endtask
  // Released lines flip so a stale word never looks valid
  task idle;
    xfer_valid = 1'b0;
    xfer_instr = ~xfer_instr;
    privileged = ~privileged;
  endtask
endmodule // core_model
`default_nettype wire

/* File: sim/id_regs_checker.sv */
// Assertions on the register-zero answers.
// Assumes the port names of the bound top module.
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module id_regs_checker #(parameter DCACHE_KB = 8, parameter ICACHE_KB = 16) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic xfer_valid,
  input wire logic [31:0] xfer_instr,
  input wire logic privileged,
  input wire logic read_valid_r,
  input wire logic [31:0] read_data_r,
  input wire logic [3:0] read_rd_r,
  input wire logic undef_trap_r
);
  // Descriptors: size code, four-way, present, eight-word lines
  localparam [23:0] DESC = {2'h0, 4'($clog2(DCACHE_KB) + 1), 8'h48, 4'($clog2(ICACHE_KB) + 1), 6'h12};
  localparam [31:0] ID_WORD = 32'h5a121233; // Arbitrary value
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Transfer offered to this coprocessor while enabled
  sequence take_any;
    clk_en && xfer_valid && xfer_instr[11:8] == 4'hf;
  endsequence
  // Accepted privileged read, then one with a chosen selector
  sequence take_rd;
    take_any ##0 privileged && xfer_instr[20] && xfer_instr[19:16] == 4'h0;
  endsequence
  sequence rd_op(logic [2:0] k);
    take_rd ##0 xfer_instr[7:5] == k;
  endsequence
  read_answer_a: assert property (take_rd |=> read_valid_r && !undef_trap_r)
    else $error("no read answer");
  trap_answer_a: assert property (take_any ##0 !privileged |=> undef_trap_r && !read_valid_r)
    else $error("no trap");
  no_answer_a: assert property (clk_en && !(xfer_valid && xfer_instr[11:8] == 4'hf &&
    (!privileged || xfer_instr[20] && xfer_instr[19:16] == 4'h0)) |=> !read_valid_r && !undef_trap_r)
    else $error("stray answer");
  write_quiet_a: assert property (take_any ##0 privileged && !xfer_instr[20] |=> !read_valid_r && !undef_trap_r)
    else $error("answer to a write");
  id_word_a: assert property (take_rd ##0 xfer_instr[7:5] != 3'h1 && xfer_instr[7:5] != 3'h2
    |=> read_data_r == ID_WORD) else $error("bad id");
  cache_top_a: assert property (rd_op(3'h1) |=> read_data_r[31:24] == 8'h1d)
    else $error("bad cache top");
  cache_desc_a: assert property (rd_op(3'h1) |=> read_data_r[23:0] == DESC)
    else $error("bad desc");
  tcm_word_a: assert property (rd_op(3'h2) |=> read_data_r == 32'h0)
    else $error("bad tcm");
  rd_index_a: assert property (take_rd |=> read_rd_r == $past(xfer_instr[15:12]))
    else $error("bad rd");
  freeze_hold_a: assert property (!clk_en |=> $stable(read_valid_r) && $stable(undef_trap_r) &&
    $stable(read_data_r) && $stable(read_rd_r)) else $error("moved while frozen");
endmodule // id_regs_checker
bind sysctl_coproc_id_regs id_regs_checker #(.DCACHE_KB(DCACHE_KB), .ICACHE_KB(ICACHE_KB)) chk_u (
  .clk(clk), .reset(reset), .clk_en(clk_en), .xfer_valid(xfer_valid), .xfer_instr(xfer_instr),
  .privileged(privileged), .read_valid_r(read_valid_r), .read_data_r(read_data_r), .read_rd_r(read_rd_r),
  .undef_trap_r(undef_trap_r));
`default_nettype wire

/* File: sim/sysctl_coproc_id_regs_tb.sv */
// Self-checking bench for the register-zero read group.
// Assumes core_model drives the transfer inputs.
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module sysctl_coproc_id_regs_tb;
  logic clk = 1'b0, reset = 1'b1, en = 1'b1, xfer_valid, privileged, read_valid_r, undef_trap_r, pv, wr;
  logic [31:0] xfer_instr, read_data_r;
  logic [3:0] read_rd_r, pri, rd;
  logic [2:0] op;
  logic [36:0] q[$];
  int err_count = 0, checks = 0;
  wire [36:0] seen = {undef_trap_r, read_valid_r ? {read_rd_r, read_data_r} : 36'h0};
  always #50 clk = ~clk;
  sysctl_coproc_id_regs dut_u (.clk(clk), .reset(reset), .clk_en(en), .xfer_valid(xfer_valid),
    .xfer_instr(xfer_instr), .privileged(privileged), .read_valid_r(read_valid_r), .read_data_r(read_data_r),
    .read_rd_r(read_rd_r), .undef_trap_r(undef_trap_r));
  core_model core_u (.clk(clk), .xfer_valid(xfer_valid), .xfer_instr(xfer_instr), .privileged(privileged));
  task check(input logic [36:0] s, input logic [36:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %0t %h vs %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Each answer takes the oldest note
  always @(posedge clk)
    if (read_valid_r === 1'b1 || undef_trap_r === 1'b1)
      check(seen, q.size() ? q.pop_front() : 37'h1f);
  // Hang guard, well beyond forty transfers
  initial
  begin
    #20000;
    err_count++;
    print_verdict();
  end
  // Every selector once, then random back-to-back traffic
  initial
  begin
    void'($urandom(32'h2fbf04cc));
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      op = (i < 8) ? i[2:0] : 3'($urandom);
      rd = 4'($urandom);
      pv = (i < 8) || ($urandom % 4 != 0);
      wr = (i >= 8) && ($urandom % 4 == 0);
      pri = (wr || (i >= 8 && $urandom % 4 == 0)) ? 4'($urandom % 15 + 1) : 4'h0;
      if (!pv)
        q.push_back({1'b1, 36'h0});
      else if (pri == 4'h0)
        q.push_back({1'b0, rd, op == 3'h1 ? 32'h1d112152 : op == 3'h2 ? 32'h0 : 32'h5a121233});
      core_u.issue(pri, op, rd, pv, !wr);
    end
    core_u.idle();
    repeat (3) @(posedge clk);
    check(37'(q.size()), 37'h0);
    // Frozen enable: a request must be ignored
    #1 en = 1'b0;
    core_u.issue(4'h0, 3'h1, 4'h5, 1'b1, 1'b1);
    core_u.idle();
    @(posedge clk);
    #1 en = 1'b1;
    // Mid-run reset clears the held read, then one read right after release
    reset = 1'b1;
    @(posedge clk);
    #1 reset = 1'b0;
    check({1'b0, read_rd_r, read_data_r}, 37'h0);
    q.push_back({1'b0, 4'h6, 32'h5a121233});
    core_u.issue(4'h0, 3'h0, 4'h6, 1'b1, 1'b1);
    core_u.idle();
    repeat (3) @(posedge clk);
    check(37'(q.size()), 37'h0);
    print_verdict();
  end
endmodule // sysctl_coproc_id_regs_tb
`default_nettype wire
